//--- hw/pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_PC_W 21
`define PFC_SP_W 5
`define PFC_STK_DEPTH 31
`define PFC_PC_RST 21'h0_0000
`define PFC_VEC_HIGH 21'h0_0008
`define PFC_VEC_LOW 21'h0_0018
`define PFC_PC_STEP 21'h0_0002
`define PFC_PHASE_RST 4'h1
`define PFC_PH_ONE 0
`define PFC_PH_TWO 1
`define PFC_PH_THREE 2
`define PFC_PH_FOUR 3

`define PFC_ADDR_PCL 3'h0
`define PFC_ADDR_PC_HIGH_LATCH 3'h1
`define PFC_ADDR_PC_UPPER_LATCH 3'h2
`define PFC_ADDR_STKPTR 3'h3
`define PFC_ADDR_STATUS 3'h4
`define PFC_ADDR_WORKING_REGISTER 3'h5
`define PFC_ADDR_BSR 3'h6
`define PFC_STK_FULL_BIT 7
`define PFC_STK_UNF_BIT 6
`define PFC_UPPER_W 5

`define PFC_SEC_MASK 16'hf000
`define PFC_SEC_VAL 16'hf000
`define PFC_GOTO_MASK 16'hff00
`define PFC_GOTO_VAL 16'hef00
`define PFC_CALL_MASK 16'hfe00
`define PFC_CALL_VAL 16'hec00
`define PFC_CALL_FAST_BIT 8
`define PFC_BRA_MASK 16'hf800
`define PFC_BRA_VAL 16'hd000
`define PFC_RELATIVE_SUBROUTINE_CALL_VAL 16'hd800
`define PFC_RET_MASK 16'hfffe
`define PFC_RETURN_VAL 16'h0012
`define PFC_RETFIE_VAL 16'h0010
`define PFC_RET_FAST_BIT 0
`define PFC_FILE_TO_FILE_MOVE_MASK 16'hf000
`define PFC_FILE_TO_FILE_MOVE_VAL 16'hc000
`define PFC_LOAD_INDIRECT_POINTER_MASK 16'hffc0
`define PFC_LOAD_INDIRECT_POINTER_VAL 16'hee00
`define PFC_NOP_VAL 16'h0000

`endif

//--- hw/pfc_pkg.sv
package pfc_pkg;
	typedef enum logic [3:0] {
		PFC_OP_PLAIN = 4'b0000,
		PFC_OP_GOTO = 4'b0001,
		PFC_OP_CALL = 4'b0010,
		PFC_OP_BRA = 4'b0011,
		PFC_OP_RELATIVE_SUBROUTINE_CALL = 4'b0100,
		PFC_OP_RETURN = 4'b0101,
		PFC_OP_RETFIE = 4'b0110,
		PFC_OP_TWO_WORD = 4'b0111,
		PFC_OP_NOP = 4'b1000
	} pfc_op_e;
endpackage

//--- hw/pfc_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_phase_gen (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	output logic [3:0] o_phase
);
	// A one-hot ring keeps the four phase enables free of decode glitches.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			o_phase <= `PFC_PHASE_RST;
		else
			o_phase <= {o_phase[2:0], o_phase[3]};
	end
endmodule
`default_nettype wire

//--- hw/pfc_ret_stack.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_ret_stack #(
	parameter int DEPTH = `PFC_STK_DEPTH,
	parameter int AW = `PFC_PC_W,
	parameter int PW = `PFC_SP_W
) (
	input wire logic i_sys_clk,
	input wire logic i_por,
	input wire logic i_sp_rst,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [AW-1:0] i_push_data,
	input wire logic i_sw_wr,
	input wire logic [7:0] i_sw_data,
	output logic [AW-1:0] o_tos,
	output logic [PW-1:0] o_sp,
	output logic o_full,
	output logic o_unf,
	output logic o_event
);
	logic [AW-1:0] mem [1:DEPTH];
	wire at_top = (o_sp == PW'(DEPTH));
	wire at_bottom = (o_sp == '0);
	wire [PW-1:0] sp_inc = at_top ? o_sp : PW'(o_sp + 1'b1);
	wire full_set = i_push && (o_sp >= PW'(DEPTH - 1));
	wire unf_set = i_pop && at_bottom;
	wire full_clr = i_sw_wr && !i_sw_data[`PFC_STK_FULL_BIT];
	wire unf_clr = i_sw_wr && !i_sw_data[`PFC_STK_UNF_BIT];

	// An empty stack hands back zero, which sends the program to the reset vector.
	assign o_tos = at_bottom ? '0 : mem[o_sp];

	always_ff @(posedge i_sys_clk)
	begin
		if (i_push)
			mem[sp_inc] <= i_push_data;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_por || i_sp_rst)
			o_sp <= '0;
		else if (i_push)
			o_sp <= sp_inc;
		else if (i_pop && !at_bottom)
			o_sp <= PW'(o_sp - 1'b1);
		else if (i_sw_wr)
			o_sp <= i_sw_data[PW-1:0];
	end

	// The flags ignore the stack reset; a new event wins over a clear in the same cycle.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_por)
		begin
			o_full <= 1'b0;
			o_unf <= 1'b0;
			o_event <= 1'b0;
		end
		else
		begin
			o_full <= full_set || (o_full && !full_clr);
			o_unf <= unf_set || (o_unf && !unf_clr);
			o_event <= full_set || unf_set;
		end
	end
endmodule
`default_nettype wire

//--- hw/pfc_core.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_core #(
	parameter int PC_W = `PFC_PC_W,
	parameter int SP_W = `PFC_SP_W,
	parameter int STK_DEPTH = `PFC_STK_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_stack_overflow_reset_enable,
	input wire logic [2:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic [PC_W-1:0] o_pm_addr,
	input wire logic [15:0] i_pm_data,
	output logic [15:0] o_instruction_latch,
	output logic o_exec_valid,
	output logic [11:0] o_dm_addr,
	output logic o_dm_rd,
	output logic o_dm_wr,
	input wire logic i_irq_high,
	input wire logic i_irq_low,
	output logic o_irq_ack,
	output logic [3:0] o_phase,
	output logic o_dev_reset,
	output logic [7:0] o_status,
	output logic [7:0] o_working_register,
	output logic [7:0] o_bank_select_register
);
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	logic [7:0] pc_high_latch_reg;
	logic [PC_W-17:0] pc_upper_latch_reg;
	logic [15:0] ir_reg;
	logic exec_valid_reg;
	logic flush_pend_reg;
	logic dev_rst_reg;
	logic [7:0] status_reg;
	logic [7:0] working_register_reg;
	logic [7:0] bsr_reg;
	logic [7:0] sh_status_reg;
	logic [7:0] sh_working_register_reg;
	logic [7:0] sh_bsr_reg;
	logic [7:0] rdata_reg;
	logic [PC_W-1:0] pm_addr_reg;
	logic [11:0] dm_addr_reg;
	logic dm_rd_reg;
	logic dm_wr_reg;
	logic irq_ack_reg;
	logic [PC_W-1:0] tos;
	logic [SP_W-1:0] sp;
	logic stk_full;
	logic stk_unf;
	logic stk_event;
	pfc_pkg::pfc_op_e op;

	wire core_rst = i_rst || dev_rst_reg;
	wire ph1 = o_phase[`PFC_PH_ONE];
	wire ph2 = o_phase[`PFC_PH_TWO];
	wire ph3 = o_phase[`PFC_PH_THREE];
	wire ph4 = o_phase[`PFC_PH_FOUR];

	pfc_phase_gen i_pfc_phase_gen (
		.i_sys_clk(i_sys_clk),
		.i_rst(core_rst),
		.o_phase(o_phase)
	);

	// Instruction decode of the word now in execution.
	wire is_sec = (ir_reg & `PFC_SEC_MASK) == `PFC_SEC_VAL;
	wire is_goto = (ir_reg & `PFC_GOTO_MASK) == `PFC_GOTO_VAL;
	wire is_call = (ir_reg & `PFC_CALL_MASK) == `PFC_CALL_VAL;
	wire is_bra = (ir_reg & `PFC_BRA_MASK) == `PFC_BRA_VAL;
	wire is_relative_subroutine_call = (ir_reg & `PFC_BRA_MASK) == `PFC_RELATIVE_SUBROUTINE_CALL_VAL;
	wire is_return = (ir_reg & `PFC_RET_MASK) == `PFC_RETURN_VAL;
	wire is_retfie = (ir_reg & `PFC_RET_MASK) == `PFC_RETFIE_VAL;
	wire is_two = ((ir_reg & `PFC_FILE_TO_FILE_MOVE_MASK) == `PFC_FILE_TO_FILE_MOVE_VAL) || ((ir_reg & `PFC_LOAD_INDIRECT_POINTER_MASK) == `PFC_LOAD_INDIRECT_POINTER_VAL);

	// The lone second word decodes as a no-op, ahead of everything else.
	assign op = (is_sec || ir_reg == `PFC_NOP_VAL) ? pfc_pkg::PFC_OP_NOP :
		is_goto ? pfc_pkg::PFC_OP_GOTO :
		is_call ? pfc_pkg::PFC_OP_CALL :
		is_bra ? pfc_pkg::PFC_OP_BRA :
		is_relative_subroutine_call ? pfc_pkg::PFC_OP_RELATIVE_SUBROUTINE_CALL :
		is_return ? pfc_pkg::PFC_OP_RETURN :
		is_retfie ? pfc_pkg::PFC_OP_RETFIE :
		is_two ? pfc_pkg::PFC_OP_TWO_WORD :
		pfc_pkg::PFC_OP_PLAIN;

	wire exec_go = ph4 && exec_valid_reg;
	wire op_call = op == pfc_pkg::PFC_OP_CALL;
	wire op_relative_subroutine_call = op == pfc_pkg::PFC_OP_RELATIVE_SUBROUTINE_CALL;
	wire op_ret = (op == pfc_pkg::PFC_OP_RETURN) || (op == pfc_pkg::PFC_OP_RETFIE);
	wire op_abs = (op == pfc_pkg::PFC_OP_GOTO) || op_call;
	wire op_rel = (op == pfc_pkg::PFC_OP_BRA) || op_relative_subroutine_call;
	wire branch_take = exec_go && (op_abs || op_rel || op_ret);
	wire fast_bit = op_call ? ir_reg[`PFC_CALL_FAST_BIT] : ir_reg[`PFC_RET_FAST_BIT];

	// Interrupts are held off while a branch or a two-word instruction executes,
	// since flushing the second word would strand it.
	wire irq_req = i_irq_high || i_irq_low;
	wire irq_take = ph4 && exec_valid_reg && irq_req && !branch_take && (op != pfc_pkg::PFC_OP_TWO_WORD);
	wire [PC_W-1:0] irq_vec = i_irq_high ? `PFC_VEC_HIGH : `PFC_VEC_LOW;

	// The second word of an absolute call or jump is on the memory bus in this phase.
	wire [PC_W-1:0] abs_target = {i_pm_data[11:0], ir_reg[7:0], 1'b0};
	wire [PC_W-1:0] rel_off = {{(PC_W-12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
	wire [PC_W-1:0] pc_this = PC_W'(pc_reg - `PFC_PC_STEP);
	wire [PC_W-1:0] rel_target = PC_W'(pc_this + rel_off);
	wire [PC_W-1:0] branch_target = op_abs ? abs_target : op_rel ? rel_target : tos;

	wire push = (exec_go && (op_call || op_relative_subroutine_call)) || irq_take;
	wire pop = exec_go && op_ret;
	wire [PC_W-1:0] push_data = (exec_go && op_call) ? pc_reg : pc_this;
	wire shadow_load = irq_take || (exec_go && op_call && fast_bit);
	wire shadow_restore = pop && fast_bit;

	// Register bus decode.
	wire wr_pcl = i_reg_wr && (i_reg_addr == `PFC_ADDR_PCL);
	wire wr_lath = i_reg_wr && (i_reg_addr == `PFC_ADDR_PC_HIGH_LATCH);
	wire wr_latu = i_reg_wr && (i_reg_addr == `PFC_ADDR_PC_UPPER_LATCH);
	wire wr_stk = i_reg_wr && (i_reg_addr == `PFC_ADDR_STKPTR);
	wire wr_status = i_reg_wr && (i_reg_addr == `PFC_ADDR_STATUS);
	wire wr_working_register = i_reg_wr && (i_reg_addr == `PFC_ADDR_WORKING_REGISTER);
	wire wr_bsr = i_reg_wr && (i_reg_addr == `PFC_ADDR_BSR);
	wire rd_pcl = i_reg_rd && (i_reg_addr == `PFC_ADDR_PCL);
	wire [7:0] stkptr_view = {stk_full, stk_unf, {(8-SP_W-2){1'b0}}, sp};
	wire [7:0] rd_mux = (i_reg_addr == `PFC_ADDR_PCL) ? pc_reg[7:0] :
		(i_reg_addr == `PFC_ADDR_PC_HIGH_LATCH) ? pc_high_latch_reg :
		(i_reg_addr == `PFC_ADDR_PC_UPPER_LATCH) ? {{(8-`PFC_UPPER_W){1'b0}}, pc_upper_latch_reg} :
		(i_reg_addr == `PFC_ADDR_STKPTR) ? stkptr_view :
		(i_reg_addr == `PFC_ADDR_STATUS) ? status_reg :
		(i_reg_addr == `PFC_ADDR_WORKING_REGISTER) ? working_register_reg :
		(i_reg_addr == `PFC_ADDR_BSR) ? bsr_reg :
		8'h00;

	// A low-byte write lands together with both latches and restarts the fetch.
	wire [PC_W-1:0] pcl_target = {pc_upper_latch_reg, pc_high_latch_reg, i_reg_wdata[7:1], 1'b0};
	wire [PC_W-1:0] pc_step = PC_W'(pc_reg + `PFC_PC_STEP);
	wire file_op = exec_valid_reg && (op == pfc_pkg::PFC_OP_PLAIN);

	pfc_ret_stack #(
		.DEPTH(STK_DEPTH),
		.AW(PC_W),
		.PW(SP_W)
	) i_pfc_ret_stack (
		.i_sys_clk(i_sys_clk),
		.i_por(i_rst),
		.i_sp_rst(dev_rst_reg),
		.i_push(push),
		.i_pop(pop),
		.i_push_data(push_data),
		.i_sw_wr(wr_stk),
		.i_sw_data(i_reg_wdata),
		.o_tos(tos),
		.o_sp(sp),
		.o_full(stk_full),
		.o_unf(stk_unf),
		.o_event(stk_event)
	);

	// A branch or vector decided in phase four wins over a software write in the same cycle.
	always_comb
	begin
		if (branch_take)
			pc_next = branch_target;
		else if (irq_take)
			pc_next = irq_vec;
		else if (wr_pcl)
			pc_next = pcl_target;
		else if (ph1)
			pc_next = pc_step;
		else
			pc_next = pc_reg;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
			pc_reg <= `PFC_PC_RST;
		else
			pc_reg <= {pc_next[PC_W-1:1], 1'b0};
	end

	// The fetch address is the counter as it stood before the phase-one step.
	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
			pm_addr_reg <= `PFC_PC_RST;
		else if (ph1)
			pm_addr_reg <= pc_reg;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			pc_high_latch_reg <= 8'h00;
			pc_upper_latch_reg <= '0;
		end
		else if (rd_pcl)
		begin
			pc_high_latch_reg <= pc_reg[15:8];
			pc_upper_latch_reg <= pc_reg[PC_W-1:16];
		end
		else
		begin
			if (wr_lath)
				pc_high_latch_reg <= i_reg_wdata;
			if (wr_latu)
				pc_upper_latch_reg <= i_reg_wdata[`PFC_UPPER_W-1:0];
		end
	end

	// Fetch and execute overlap: the word latched now executes over the next four phases.
	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
		begin
			ir_reg <= `PFC_NOP_VAL;
			exec_valid_reg <= 1'b0;
			flush_pend_reg <= 1'b0;
		end
		else if (ph4)
		begin
			ir_reg <= i_pm_data;
			exec_valid_reg <= !(branch_take || irq_take || flush_pend_reg || wr_pcl);
			flush_pend_reg <= 1'b0;
		end
		else if (wr_pcl)
			flush_pend_reg <= 1'b1;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
		begin
			dm_rd_reg <= 1'b0;
			dm_wr_reg <= 1'b0;
			dm_addr_reg <= 12'h000;
		end
		else
		begin
			dm_rd_reg <= ph1 && file_op;
			dm_wr_reg <= ph3 && file_op;
			if (ph1)
				dm_addr_reg <= {bsr_reg[3:0], ir_reg[7:0]};
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
		begin
			sh_status_reg <= 8'h00;
			sh_working_register_reg <= 8'h00;
			sh_bsr_reg <= 8'h00;
		end
		else if (shadow_load)
		begin
			sh_status_reg <= status_reg;
			sh_working_register_reg <= working_register_reg;
			sh_bsr_reg <= bsr_reg;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (core_rst)
		begin
			status_reg <= 8'h00;
			working_register_reg <= 8'h00;
			bsr_reg <= 8'h00;
		end
		else if (shadow_restore)
		begin
			status_reg <= sh_status_reg;
			working_register_reg <= sh_working_register_reg;
			bsr_reg <= sh_bsr_reg;
		end
		else
		begin
			if (wr_status)
				status_reg <= i_reg_wdata;
			if (wr_working_register)
				working_register_reg <= i_reg_wdata;
			if (wr_bsr)
				bsr_reg <= i_reg_wdata;
		end
	end

	// The device reset follows the flag by one cycle so the flag is already set.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			dev_rst_reg <= 1'b0;
			irq_ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			dev_rst_reg <= stk_event && i_stack_overflow_reset_enable;
			irq_ack_reg <= irq_take;
			rdata_reg <= i_reg_rd ? rd_mux : 8'h00;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_pm_addr = pm_addr_reg;
	assign o_instruction_latch = ir_reg;
	assign o_exec_valid = exec_valid_reg;
	assign o_dm_addr = dm_addr_reg;
	assign o_dm_rd = dm_rd_reg;
	assign o_dm_wr = dm_wr_reg;
	assign o_irq_ack = irq_ack_reg;
	assign o_dev_reset = dev_rst_reg;
	assign o_status = status_reg;
	assign o_working_register = working_register_reg;
	assign o_bank_select_register = bsr_reg;
endmodule
`default_nettype wire

//--- sim/pfc_core_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_core_chk #(
	parameter int PC_W = 21
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_stack_overflow_reset_enable,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [PC_W-1:0] o_pm_addr,
	input wire logic o_exec_valid,
	input wire logic o_dm_rd,
	input wire logic o_dm_wr,
	input wire logic o_irq_ack,
	input wire logic [3:0] o_phase,
	input wire logic o_dev_reset
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_rest;
		o_phase[1] ##1 o_phase[2] ##1 o_phase[3] ##1 o_phase[0];
	endsequence
	// Only checked with the stack reset option off, since a device reset restarts the phases.
	AST_PHASE_CYCLE: assert property (o_phase[0] && !i_stack_overflow_reset_enable |=> s_rest)
		else $error("phase sequence broken");
	AST_PHASE_ONEHOT: assert property ($onehot(o_phase))
		else $error("phase not one-hot");
	AST_PC_EVEN: assert property (o_pm_addr[0] == 1'b0)
		else $error("fetch address odd");
	AST_ADDR_PH1: assert property ($changed(o_pm_addr) |-> $past(o_phase[0]) || $past(o_dev_reset) || o_dev_reset)
		else $error("fetch address moved outside phase one");
	AST_DM_RD_PH2: assert property (o_dm_rd |-> o_phase[1])
		else $error("data read outside phase two");
	AST_DM_WR_PH4: assert property (o_dm_wr |-> o_phase[3])
		else $error("data write outside phase four");
	AST_FLUSH_NOP: assert property (!o_exec_valid |-> !o_dm_rd && !o_dm_wr)
		else $error("flushed word touched data memory");
	AST_VECTOR: assert property ($rose(o_irq_ack) |-> ##[0:8] (o_pm_addr == 21'h0_0008 || o_pm_addr == 21'h0_0018))
		else $error("interrupt did not vector");
	AST_NO_DEVRST: assert property (!i_stack_overflow_reset_enable && !$past(i_stack_overflow_reset_enable) |-> !o_dev_reset)
		else $error("device reset with option off");
	AST_DEVRST_PULSE: assert property (o_dev_reset |=> !o_dev_reset)
		else $error("device reset longer than one cycle");
	AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data without a read");
endmodule
`default_nettype wire

//--- sim/pfc_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_prog_mem (
	input wire logic [20:0] i_addr,
	output logic [15:0] o_data
);
	logic [15:0] mem [0:1023];
	// Indexing from bit 1 puts each word's low byte at an even address.
	assign o_data = mem[i_addr[10:1]];
	initial
	begin
		for (int k = 0; k < 1024; k++)
		begin
			mem[k] = 16'h0000;
		end
		mem[1] = 16'hef20;
		mem[2] = 16'hf000;
		mem[4] = 16'h0011;
		mem[12] = 16'h0010;
		mem[32] = 16'h0012;
		mem[136] = 16'h2400;
		mem[137] = 16'hd002;
	end
endmodule
`default_nettype wire

//--- sim/pfc_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_core_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b0;
	logic [2:0] ra = 3'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ih = 1'b0;
	logic il = 1'b0;
	logic [7:0] rdat;
	logic [20:0] pma;
	logic [15:0] pmd;
	logic ack;
	logic [3:0] ph;
	logic drst;
	logic [7:0] working_register;
	logic [7:0] stat;
	logic [7:0] bank_select_register;
	logic [15:0] ilat;
	logic [11:0] dma;
	int bad_count = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	pfc_core i_pfc_core (.i_sys_clk(clk), .i_rst(rst), .i_stack_overflow_reset_enable(en), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_pm_addr(pma), .i_pm_data(pmd),
		.o_instruction_latch(ilat), .o_exec_valid(), .o_dm_addr(dma), .o_dm_rd(), .o_dm_wr(), .i_irq_high(ih),
		.i_irq_low(il), .o_irq_ack(ack), .o_phase(ph), .o_dev_reset(drst), .o_status(stat),
		.o_working_register(working_register), .o_bank_select_register(bank_select_register));
	pfc_prog_mem i_pfc_prog_mem (.i_addr(pma), .o_data(pmd));
	task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask
	task automatic wait_addr(input logic [20:0] a);
		for (int n = 0; n < 200 && pma !== a; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("fetch address", a, pma);
	endtask
	task automatic t_trace;
		logic [20:0] exp [6] = '{21'h0, 21'h2, 21'h4, 21'h40, 21'h42, 21'h0};
		logic [20:0] last;
		int k;
		k = 1;
		last = pma;
		chk("reset address", exp[0], pma);
		for (int n = 0; n < 80 && k < 6; n++)
		begin
			@(posedge clk);
			#1;
			if (pma !== last)
			begin
				chk("fetch trace", exp[k], pma);
				k++;
				last = pma;
			end
		end
		chk("trace length", 21'h6, 21'(k));
	endtask
	task automatic t_unf;
		logic [7:0] d;
		reg_rd(`PFC_ADDR_STKPTR, d);
		chk("underflow flag", 21'h40, {13'h0, d});
		reg_wr(`PFC_ADDR_STKPTR, 8'h00);
		reg_rd(`PFC_ADDR_STKPTR, d);
		chk("flag after clear", 21'h0, {13'h0, d});
	endtask
	task automatic t_pcl;
		logic [7:0] d;
		reg_wr(`PFC_ADDR_BSR, 8'h03);
		reg_wr(`PFC_ADDR_PC_HIGH_LATCH, 8'h01);
		// Start in phase one so the write lands clear of a branch decision.
		@(posedge clk iff ph[0] === 1'b1);
		reg_wr(`PFC_ADDR_PCL, 8'h11);
		wait_addr(21'h110);
		repeat (3) @(posedge clk);
		#1;
		chk("instruction latch", 21'h2400, {5'h0, ilat});
		@(posedge clk);
		#1;
		chk("data address", 21'h300, {9'h0, dma});
		wait_addr(21'h114);
		repeat (4) @(posedge clk);
		#1;
		chk("branch target", 21'h118, pma);
		reg_wr(`PFC_ADDR_PC_HIGH_LATCH, 8'h55);
		reg_rd(`PFC_ADDR_PCL, d);
		reg_rd(`PFC_ADDR_PC_HIGH_LATCH, d);
		chk("high latch", 21'h01, {13'h0, d});
	endtask
	task automatic t_irq(input logic hi, input logic [20:0] vec, input logic [7:0] exp);
		reg_wr(`PFC_ADDR_WORKING_REGISTER, 8'h5a);
		reg_wr(`PFC_ADDR_STATUS, 8'h5a);
		reg_wr(`PFC_ADDR_BSR, 8'h5a);
		ih <= hi;
		il <= !hi;
		for (int n = 0; n < 100 && ack !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("interrupt ack", 21'h1, {20'h0, ack});
		@(posedge clk);
		ih <= 1'b0;
		il <= 1'b0;
		reg_wr(`PFC_ADDR_WORKING_REGISTER, 8'h22);
		reg_wr(`PFC_ADDR_BSR, 8'h22);
		wait_addr(vec);
		wait_addr(vec + 21'h2);
		for (int n = 0; n < 20 && pma === vec + 21'h2; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("working register", {13'h0, exp}, {13'h0, working_register});
		chk("bank select register", {13'h0, exp}, {13'h0, bank_select_register});
		chk("status register", 21'h5a, {13'h0, stat});
	endtask
	task automatic t_drst;
		logic [7:0] d;
		@(posedge clk);
		en <= 1'b1;
		reg_wr(`PFC_ADDR_STKPTR, 8'h00);
		reg_wr(`PFC_ADDR_PC_HIGH_LATCH, 8'h00);
		@(posedge clk iff ph[0] === 1'b1);
		reg_wr(`PFC_ADDR_PCL, 8'h00);
		for (int n = 0; n < 200 && drst !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("device reset", 21'h1, {20'h0, drst});
		reg_rd(`PFC_ADDR_STKPTR, d);
		chk("flag kept", 21'h40, {13'h0, d});
		@(posedge clk);
		en <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reg_rd(`PFC_ADDR_STKPTR, d);
		chk("flag after power-on", 21'h0, {13'h0, d});
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_trace();
		t_unf();
		t_pcl();
		t_irq(1'b1, 21'h8, 8'h5a);
		t_irq(1'b0, 21'h18, 8'h22);
		t_drst();
		give_verdict();
	end
	initial
	begin
		#2000000;
		bad_count++;
		give_verdict();
	end
endmodule
bind pfc_core pfc_core_chk #(.PC_W(PC_W)) i_pfc_core_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_stack_overflow_reset_enable(i_stack_overflow_reset_enable), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.o_pm_addr(o_pm_addr), .o_exec_valid(o_exec_valid), .o_dm_rd(o_dm_rd), .o_dm_wr(o_dm_wr),
	.o_irq_ack(o_irq_ack), .o_phase(o_phase), .o_dev_reset(o_dev_reset));
`default_nettype wire
